/* verilog/ppfc_port_ctrl.v */
`timescale 1ns/1ps
`include "ppfc_defines.vh"
module ppfc_port_ctrl #(
    parameter SMALL_PACKAGE = 0
) (
    input wire clk_sys,
    input wire nrst,
    input wire [1:0] reg_port,
    input wire [1:0] reg_sel,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [31:0] alt_out,
    input wire [31:0] alt_oe,
    output wire [31:0] alt_in,
    input wire [31:0] pin_in,
    output wire [31:0] pin_out,
    output wire [31:0] pin_oe
);
    // ----------------------------------------
    // Register selectors
    // ----------------------------------------
    localparam [1:0] SEL_ADDR = `PPFC_SEL_ADDR;
    localparam [1:0] SEL_CTRL = `PPFC_SEL_CTRL;
    localparam [1:0] SEL_IN = `PPFC_SEL_IN;
    localparam [1:0] SEL_OUT = `PPFC_SEL_OUT;

    // ----------------------------------------
    // Flattened per-port state
    // ----------------------------------------
    wire [31:0] addr_all;
    wire [31:0] dir_all;
    wire [31:0] alt_enable_all;
    wire [31:0] open_drain_all;
    wire [31:0] out_all;
    wire [31:0] pin_sync;

    // ----------------------------------------
    // Decode and read-back nets
    // ----------------------------------------
    wire [7:0] cur_addr;
    wire [7:0] cur_dir;
    wire [7:0] cur_alt_enable;
    wire [7:0] cur_open_drain;
    wire [7:0] cur_out;
    wire [7:0] cur_in;
    wire wr_addr;
    wire wr_ctrl;
    wire wr_out;
    reg [7:0] cur_ctrl;
    reg [7:0] next_rdata;
    genvar p;

    // ----------------------------------------
    // Write decode shared by all ports
    // ----------------------------------------
    // Input-register writes match none of these and are dropped
    assign wr_addr = reg_wr && (reg_sel == SEL_ADDR);
    assign wr_ctrl = reg_wr && (reg_sel == SEL_CTRL);
    assign wr_out = reg_wr && (reg_sel == SEL_OUT);
    assign alt_in = pin_sync;

    // ----------------------------------------
    // Per-port registers and pin drive
    // ----------------------------------------
    generate
        for (p = 0; p < `PPFC_NUM_PORTS; p = p + 1) begin : g_port
            // Absent pins stay tri-stated; keeps the total at 25
            localparam [7:0] PRESENT = (p == 0) ? `PPFC_PINS_A : (p == 1) ? `PPFC_PINS_B :
                (p == 2) ? `PPFC_PINS_C : `PPFC_PINS_D;
            localparam [7:0] AF_RST = (p == 3) ? `PPFC_AF_RST_D :
                ((p == 0) && (SMALL_PACKAGE != 0)) ? `PPFC_AF_RST_A_SMALL : `PPFC_AF_RST_ABC;
            localparam [7:0] OC_RST = (p == 3) ? `PPFC_OC_RST_D : `PPFC_OC_RST_ABC;
            reg [7:0] addr_reg;
            reg [7:0] dir_reg;
            reg [7:0] pin_alt_function_enable;
            reg [7:0] pin_open_drain_select;
            reg [7:0] out_reg;
            wire port_hit;
            wire hit_addr;
            wire hit_dir;
            wire hit_af;
            wire hit_oc;
            wire hit_out;
            wire [7:0] drv_val;
            wire [7:0] drv_en;
            wire [7:0] pin_masked;

            // ----------------------------------------
            // Sub-register write strobes
            // ----------------------------------------
            assign port_hit = (reg_port == p);
            assign hit_addr = wr_addr && port_hit;
            // Control writes with an unknown index hit nothing and are ignored
            assign hit_dir = wr_ctrl && port_hit && (addr_reg == `PPFC_IDX_DIR);
            assign hit_af = wr_ctrl && port_hit && (addr_reg == `PPFC_IDX_AF);
            assign hit_oc = wr_ctrl && port_hit && (addr_reg == `PPFC_IDX_OC);
            assign hit_out = wr_out && port_hit;

            always @(posedge clk_sys) begin
                if (!nrst) begin
                    addr_reg <= 8'h00;
                end else if (hit_addr) begin
                    addr_reg <= reg_wdata;
                end
            end

            always @(posedge clk_sys) begin
                if (!nrst) begin
                    dir_reg <= `PPFC_DIR_RST;
                end else if (hit_dir) begin
                    dir_reg <= reg_wdata;
                end
            end

            always @(posedge clk_sys) begin
                if (!nrst) begin
                    pin_alt_function_enable <= AF_RST;
                end else if (hit_af) begin
                    pin_alt_function_enable <= reg_wdata;
                end
            end

            always @(posedge clk_sys) begin
                if (!nrst) begin
                    pin_open_drain_select <= OC_RST;
                end else if (hit_oc) begin
                    pin_open_drain_select <= reg_wdata;
                end
            end

            always @(posedge clk_sys) begin
                if (!nrst) begin
                    out_reg <= `PPFC_OUT_RST;
                end else if (hit_out) begin
                    out_reg <= reg_wdata;
                end
            end

            // ----------------------------------------
            // Pin drive mux
            // ----------------------------------------
            // Direction bit 1 means input, 0 output
            assign drv_val = (pin_alt_function_enable & alt_out[p*8 +: 8]) |
                (~pin_alt_function_enable & out_reg);
            assign drv_en = (pin_alt_function_enable & alt_oe[p*8 +: 8]) |
                (~pin_alt_function_enable & ~dir_reg);
            // Open-drain applied after the mux so alternate functions obey it too
            assign pin_out[p*8 +: 8] = drv_val & ~pin_open_drain_select;
            assign pin_oe[p*8 +: 8] = PRESENT & drv_en &
                (~pin_open_drain_select | ~drv_val);

            // ----------------------------------------
            // Read-back taps and input sync
            // ----------------------------------------
            assign addr_all[p*8 +: 8] = addr_reg;
            assign dir_all[p*8 +: 8] = dir_reg;
            assign alt_enable_all[p*8 +: 8] = pin_alt_function_enable;
            assign open_drain_all[p*8 +: 8] = pin_open_drain_select;
            assign out_all[p*8 +: 8] = out_reg;
            assign pin_masked = pin_in[p*8 +: 8] & PRESENT;
            ppfc_pin_sync u_sync (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .pin_raw(pin_masked),
                .pin_value(pin_sync[p*8 +: 8])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    assign cur_addr = addr_all[reg_port*8 +: 8];
    assign cur_dir = dir_all[reg_port*8 +: 8];
    assign cur_alt_enable = alt_enable_all[reg_port*8 +: 8];
    assign cur_open_drain = open_drain_all[reg_port*8 +: 8];
    assign cur_out = out_all[reg_port*8 +: 8];
    assign cur_in = pin_sync[reg_port*8 +: 8];

    // Unused sub-register indices read as zero
    always @* begin
        case (cur_addr)
            `PPFC_IDX_DIR: cur_ctrl = cur_dir;
            `PPFC_IDX_AF: cur_ctrl = cur_alt_enable;
            `PPFC_IDX_OC: cur_ctrl = cur_open_drain;
            default: cur_ctrl = 8'h00;
        endcase
    end

    always @* begin
        case (reg_sel)
            SEL_ADDR: next_rdata = cur_addr;
            SEL_CTRL: next_rdata = cur_ctrl;
            SEL_IN: next_rdata = cur_in;
            SEL_OUT: next_rdata = cur_out;
            default: next_rdata = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Registered read data
    // ----------------------------------------
    // One cycle of latency, traded for a clean flip-flop data output
    always @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // ppfc_port_ctrl

/* verilog/ppfc_defines.vh */
`ifndef PPFC_DEFINES_VH
`define PPFC_DEFINES_VH
// ----------------------------------------
// Port count and sub-register indices
// ----------------------------------------
`define PPFC_NUM_PORTS 4
`define PPFC_IDX_DIR 8'h01
`define PPFC_IDX_AF 8'h02
`define PPFC_IDX_OC 8'h03
// ----------------------------------------
// Register selector codes
// ----------------------------------------
`define PPFC_SEL_ADDR 2'h0
`define PPFC_SEL_CTRL 2'h1
`define PPFC_SEL_IN 2'h2
`define PPFC_SEL_OUT 2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PPFC_AF_RST_ABC 8'h00
`define PPFC_AF_RST_D 8'h01
`define PPFC_AF_RST_A_SMALL 8'h04
`define PPFC_OC_RST_ABC 8'h00
`define PPFC_OC_RST_D 8'h01
`define PPFC_DIR_RST 8'hFF
`define PPFC_OUT_RST 8'h00
// ----------------------------------------
// Pins present per port (25 total)
// ----------------------------------------
`define PPFC_PINS_A 8'hFF
`define PPFC_PINS_B 8'hFF
`define PPFC_PINS_C 8'hFF
`define PPFC_PINS_D 8'h01
`endif

/* verilog/ppfc_pin_sync.v */
`timescale 1ns/1ps
// ----------------------------------------
// Three-stage pin input synchroniser
// ----------------------------------------
module ppfc_pin_sync (
    input wire clk_sys,
    input wire nrst,
    input wire [7:0] pin_raw,
    output reg [7:0] pin_value
);
    reg [7:0] stage1;
    reg [7:0] stage2;
    reg [7:0] stage3;
    wire [7:0] next_pin_value;
    genvar i;
    always @(posedge clk_sys) begin
        if (!nrst) begin
            stage1 <= 8'h00;
            stage2 <= 8'h00;
            stage3 <= 8'h00;
        end else begin
            stage1 <= pin_raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end
    // Change accepted only when stages two and three agree
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign next_pin_value[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_value[i];
        end
    endgenerate
    always @(posedge clk_sys) begin
        if (!nrst) begin
            pin_value <= 8'h00;
        end else begin
            pin_value <= next_pin_value;
        end
    end
endmodule // ppfc_pin_sync

/* sim/ppfc_pin_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Board pins with pull-ups
// ----------------------------------------
module ppfc_pin_model (
    input wire [31:0] pin_out,
    input wire [31:0] pin_oe,
    output wire [31:0] pin_in
);
    // Released pins rise to the pull-up, never keep the last value
    assign pin_in = (pin_oe & pin_out) | ~pin_oe;
endmodule // ppfc_pin_model

/* sim/ppfc_checker_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port A shadow and pin checks
// ----------------------------------------
module ppfc_checker #(
    parameter SMALL_PACKAGE = 0
) (
    input wire clk_sys,
    input wire nrst,
    input wire [1:0] reg_port,
    input wire [1:0] reg_sel,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [31:0] alt_out,
    input wire [31:0] alt_oe,
    input wire [31:0] pin_out,
    input wire [31:0] pin_oe
);
    reg [7:0] adr;
    reg [7:0] odr;
    reg [7:0] afr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Shadow of port A only, to keep the checker small
    always @(posedge clk_sys) begin
        if (!nrst) begin
            adr <= 8'h00;
            odr <= 8'h00;
            afr <= (SMALL_PACKAGE != 0) ? 8'h04 : 8'h00;
        end else if (reg_wr && reg_port == 2'h0) begin
            if (reg_sel == 2'h0) adr <= reg_wdata;
            if (reg_sel == 2'h1 && adr == 8'h03) odr <= reg_wdata;
            if (reg_sel == 2'h1 && adr == 8'h02) afr <= reg_wdata;
        end
    end
    absent_pins_a: assert property (pin_oe[31:25] == 7'h00)
        else $error("absent pin driven");
    af_read_a: assert property (reg_port == 2'h0 && reg_sel == 2'h1 && adr == 8'h02
        && !reg_wr |=> reg_rdata == afr) else $error("alt enable read wrong");
    alt_follow_a: assert property ((afr & ~odr & (pin_oe[7:0] ^ alt_oe[7:0])) == 8'h00)
        else $error("alt pin enable wrong");
    reset_quiet_a: assert property ($rose(nrst) |->
        pin_oe[23:0] == {16'h0000, afr & alt_oe[7:0]}) else $error("pin driven after reset");
    port_d_reset_a: assert property ($rose(nrst) |->
        pin_oe[24] == (alt_oe[24] && !alt_out[24])) else $error("port D reset drive wrong");
    od_read_a: assert property (reg_port == 2'h0 && reg_sel == 2'h1 && adr == 8'h03
        && !reg_wr |=> reg_rdata == odr) else $error("open drain read wrong");
    od_no_high_a: assert property ((odr & pin_out[7:0]) == 8'h00)
        else $error("open drain pin driven high");
    push_pull_a: assert property (!odr[1] && afr[1] && alt_oe[1]
        |-> pin_oe[1] && pin_out[1] == alt_out[1]) else $error("push pull lost");
    od_alt_a: assert property (odr[0] && afr[0] && alt_oe[0] |-> pin_oe[0] == !alt_out[0])
        else $error("open drain alt drive wrong");
endmodule // ppfc_checker
bind ppfc_port_ctrl ppfc_checker #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_chk (.clk_sys(clk_sys),
    .nrst(nrst), .reg_port(reg_port),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .alt_out(alt_out), .alt_oe(alt_oe), .pin_out(pin_out), .pin_oe(pin_oe));

/* sim/testbench.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Register and pin scenarios
// ----------------------------------------
module testbench;
    reg clk_sys = 1'b0;
    reg nrst = 1'b0;
    reg [1:0] reg_port = 2'h0;
    reg [1:0] reg_sel = 2'h0;
    reg reg_wr = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg [31:0] alt_out = 32'h00000000;
    reg [31:0] alt_oe = 32'hFFFFFFFF;
    wire [7:0] reg_rdata;
    wire [7:0] rdata_small;
    wire [31:0] alt_in;
    wire [31:0] pin_in;
    wire [31:0] pin_out;
    wire [31:0] pin_oe;
    integer errors = 0;
    integer n_tests = 0;
    integer p;
    ppfc_port_ctrl u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_port(reg_port), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alt_out(alt_out),
        .alt_oe(alt_oe), .alt_in(alt_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    ppfc_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    ppfc_port_ctrl #(.SMALL_PACKAGE(1)) u_dut_small (.clk_sys(clk_sys), .nrst(nrst),
        .reg_port(reg_port), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(rdata_small), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(), .pin_in(pin_in),
        .pin_out(), .pin_oe());
    initial forever #12.5 clk_sys = ~clk_sys;
    task chk(input [63:0] nm, input [7:0] exp, input [7:0] got);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    task wr(input [1:0] pt, input [1:0] s, input [7:0] d);
    begin
        @(negedge clk_sys);
        reg_port = pt;
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    end
    endtask
    task rd(input [1:0] pt, input [1:0] s, input [7:0] exp);
    begin
        @(negedge clk_sys);
        reg_port = pt;
        reg_sel = s;
        @(negedge clk_sys);
        chk("rdata", exp, reg_rdata);
    end
    endtask
    task final_report;
    begin
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        chk("oe_d", 8'h01, pin_oe[31:24]);
        for (p = 0; p < 4; p = p + 1) begin
            wr(p[1:0], 2'h0, 8'h02);
            rd(p[1:0], 2'h1, (p == 3) ? 8'h01 : 8'h00);
            if (p == 0) chk("af_small", 8'h04, rdata_small);
            wr(p[1:0], 2'h0, 8'h03);
            rd(p[1:0], 2'h1, (p == 3) ? 8'h01 : 8'h00);
        end
        wr(2'h0, 2'h0, 8'h05);
        rd(2'h0, 2'h0, 8'h05);
        wr(2'h0, 2'h1, 8'hFF);
        rd(2'h0, 2'h1, 8'h00);
        wr(2'h0, 2'h0, 8'h03);
        wr(2'h0, 2'h1, 8'h0F);
        rd(2'h0, 2'h1, 8'h0F);
        wr(2'h0, 2'h0, 8'h02);
        // Only pins 0 and 1 get an alternate function here
        wr(2'h0, 2'h1, 8'h03);
        rd(2'h0, 2'h1, 8'h03);
        wr(2'h1, 2'h0, 8'h03);
        rd(2'h1, 2'h1, 8'h00);
        wr(2'h0, 2'h0, 8'h01);
        wr(2'h0, 2'h1, 8'h00);
        wr(2'h0, 2'h3, 8'hA5);
        rd(2'h0, 2'h3, 8'hA5);
        @(negedge clk_sys);
        chk("oe", 8'hFB, pin_oe[7:0]);
        chk("out", 8'hA0, pin_out[7:0]);
        alt_out = 32'hFFFFFFFF;
        @(negedge clk_sys);
        chk("oe_alt", 8'hF8, pin_oe[7:0]);
        chk("oe_d_rel", 8'h00, pin_oe[31:24]);
        repeat (5) @(negedge clk_sys);
        rd(2'h0, 2'h2, 8'hA7);
        chk("alt_in", 8'hA7, alt_in[7:0]);
        chk("alt_in_d", 8'h01, alt_in[31:24]);
        final_report;
    end
endmodule // testbench
